// [core/ftc_core.sv]
// Frame timing control: period scaling, synchronised capture offset and pixel timestamp
`timescale 1ns/100ps
module ftc_core #(
	parameter int NOM_W          = 16,
	parameter bit PERIOD_PRESENT = 1'b1,
	parameter bit OFFSET_PRESENT = 1'b1,
	parameter bit STAMP_PRESENT  = 1'b1
) (
	// Clock and reset
	input  wire logic                  clk,
	input  wire logic                  rst_b,
	// Register port
	input  wire ftc_pkg::ftc_reg_req_t reg_req,
	output ftc_pkg::ftc_reg_rsp_t      reg_rsp,
	// Isochronous bus timing
	input  wire logic                  cycle_start,
	input  wire logic [31:0]           cycle_time,
	input  wire logic [NOM_W-1:0]      nominal_cycles,
	// Frame transmission
	input  wire logic                  tx_busy,
	output logic                       capture_pulse,
	output logic [31:0]                capture_time,
	// Pixel stream
	input  wire ftc_pkg::ftc_pix_t     pix_in,
	output ftc_pkg::ftc_pix_t          pix_out
);

	localparam int ACC_W = NOM_W + 2 * ftc_pkg::VAL_W;

	logic [ftc_pkg::VAL_W-1:0] per_val_r;
	logic                      per_on_r;
	logic [ftc_pkg::VAL_W-1:0] off_val_r;
	logic                      off_on_r;
	logic                      stamp_en_r;
	logic [ftc_pkg::VAL_W-1:0] eff_scale_r;
	logic [ftc_pkg::VAL_W-1:0] eff_off_r;
	logic [ACC_W-1:0]          acc_r;
	logic                      fired_r;
	logic                      pend_r;
	logic                      capture_r;
	logic [31:0]               stamp_r;
	logic [2:0]                idx_r;
	ftc_pkg::ftc_pix_t         pix_r;
	ftc_pkg::ftc_reg_rsp_t     rsp_r;

	// Register decode
	wire                      sel_period = reg_req.addr == ftc_pkg::ADDR_PERIOD;
	wire                      sel_offset = reg_req.addr == ftc_pkg::ADDR_OFFSET;
	wire                      sel_stamp  = reg_req.addr == ftc_pkg::ADDR_STAMP;
	wire [ftc_pkg::VAL_W-1:0] wr_val     = reg_req.wdata[ftc_pkg::VAL_W-1:0];
	wire                      wr_on      = reg_req.wdata[ftc_pkg::ON_BIT] | (|wr_val);

	wire [31:0] rd_period = {PERIOD_PRESENT, 5'h00, per_on_r, 13'h0000, per_val_r};
	wire [31:0] rd_offset = {OFFSET_PRESENT, 5'h00, off_on_r, 13'h0000, off_val_r};
	wire [31:0] rd_stamp  = {STAMP_PRESENT, 30'h00000000, stamp_en_r};
	wire [31:0] rd_mux    = sel_period ? rd_period :
	                        sel_offset ? rd_offset :
	                        sel_stamp  ? rd_stamp  : 32'h00000000;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			per_val_r  <= ftc_pkg::PERIOD_RST;
			per_on_r   <= ftc_pkg::PERIOD_ON_RST;
			off_val_r  <= ftc_pkg::OFFSET_RST;
			off_on_r   <= ftc_pkg::OFFSET_ON_RST;
			stamp_en_r <= ftc_pkg::STAMP_EN_RST;
			rsp_r      <= '0;
		end else begin
			if (reg_req.wr && sel_period) begin
				per_val_r <= wr_val;
				per_on_r  <= wr_on;
			end
			if (reg_req.wr && sel_offset) begin
				off_val_r <= wr_val;
				off_on_r  <= wr_on;
			end
			if (reg_req.wr && sel_stamp)
				stamp_en_r <= reg_req.wdata[ftc_pkg::STAMP_EN_BIT];
			rsp_r.valid <= reg_req.rd;
			rsp_r.data  <= reg_req.rd ? rd_mux : 32'h00000000;
		end
	end

	// Frame phase: one iso cycle adds 800*scale; a frame spans nominal*scale*scale; offset is off*nominal*800
	wire [ftc_pkg::VAL_W-1:0] new_scale = (per_on_r && per_val_r != '0) ? per_val_r : ftc_pkg::NOMINAL_SCALE;
	wire [ftc_pkg::VAL_W-1:0] new_off   = off_on_r ? off_val_r : '0;
	wire [ACC_W-1:0] step_u   = ACC_W'(ftc_pkg::SCALE_NUM) * ACC_W'(eff_scale_r);
	wire [ACC_W-1:0] period_u = ACC_W'(nominal_cycles) * ACC_W'(eff_scale_r) * ACC_W'(eff_scale_r);
	wire [ACC_W-1:0] acc_sum  = acc_r + step_u;
	wire             wrap     = acc_sum >= period_u;
	// All cameras restart the phase at the shared 128 s epoch
	wire             epoch    = cycle_time[31:ftc_pkg::CT_CYC_LSB] == 20'h00000;
	wire [ACC_W-1:0] acc_nxt  = epoch ? '0 : wrap ? acc_sum - period_u : acc_sum;
	wire             boundary = cycle_start && (epoch || wrap);
	// The frame that starts at a boundary already runs on the newly written offset
	wire [ftc_pkg::VAL_W-1:0] off_cur = boundary ? new_off : eff_off_r;
	wire [ACC_W-1:0] off_u    = ACC_W'(off_cur) * ACC_W'(nominal_cycles) * ACC_W'(ftc_pkg::SCALE_NUM);
	wire             due      = cycle_start && (boundary || !fired_r) && acc_nxt >= off_u;
	wire             want     = pend_r | due;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			eff_scale_r <= ftc_pkg::NOMINAL_SCALE;
			eff_off_r   <= '0;
			acc_r       <= '0;
			fired_r     <= 1'b0;
		end else begin
			if (cycle_start)
				acc_r <= acc_nxt;
			if (boundary) begin
				eff_scale_r <= new_scale;
				eff_off_r   <= new_off;
			end
			if (boundary)
				fired_r <= due;
			else if (due)
				fired_r <= 1'b1;
		end
	end

	// A capture that lands while a frame is still going out waits for it to finish
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pend_r    <= 1'b0;
			capture_r <= 1'b0;
			stamp_r   <= 32'h00000000;
		end else begin
			pend_r    <= want & tx_busy;
			capture_r <= want & ~tx_busy;
			if (due)
				stamp_r <= cycle_time;
		end
	end

	// Timestamp insertion over the first pixels of each image
	wire [2:0] cur_idx = pix_in.sof ? 3'h0 : idx_r;
	wire       replace = stamp_en_r && cur_idx < ftc_pkg::STAMP_PIXELS;
	wire [1:0] byte_sel = 2'h3 - cur_idx[1:0];
	wire [ftc_pkg::PIX_W-1:0] stamp_byte = stamp_r[{byte_sel, 3'h0} +: ftc_pkg::PIX_W];

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			idx_r <= ftc_pkg::STAMP_PIXELS;
			pix_r <= '0;
		end else begin
			if (pix_in.valid && cur_idx < ftc_pkg::STAMP_PIXELS)
				idx_r <= cur_idx + 3'h1;
			pix_r.valid <= pix_in.valid;
			pix_r.sof   <= pix_in.valid & pix_in.sof;
			pix_r.data  <= (pix_in.valid && replace) ? stamp_byte : pix_in.data;
		end
	end

	assign reg_rsp       = rsp_r;
	assign capture_pulse = capture_r;
	assign capture_time  = stamp_r;
	assign pix_out       = pix_r;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	sequence s_off_write;
		reg_req.wr && sel_period && reg_req.wdata[ftc_pkg::ON_BIT] == 1'b0 && wr_val == '0;
	endsequence
	sequence s_period_read;
		reg_req.rd && sel_period && !reg_req.wr;
	endsequence

	chk_presence_bit: assert property (s_period_read |=> reg_rsp.valid && reg_rsp.data[ftc_pkg::PRES_BIT] == PERIOD_PRESENT) else $error("presence bit wrong");
	chk_reserved_zero: assert property (reg_req.rd |=> reg_rsp.data[ftc_pkg::RSV_HI_MSB:ftc_pkg::RSV_HI_LSB] == '0 && reg_rsp.data[ftc_pkg::RSV_LO_MSB:ftc_pkg::RSV_LO_LSB] == '0) else $error("reserved bits not zero");
	chk_scale_off_read: assert property (s_off_write ##1 !reg_req.wr ##1 s_period_read |=> reg_rsp.data[ftc_pkg::ON_BIT] == 1'b0) else $error("scaling still reads on");
	chk_busy_defer: assert property (capture_r |-> !$past(tx_busy)) else $error("capture during transmission");
	chk_shadow_update: assert property ((eff_scale_r != $past(eff_scale_r)) |-> $past(boundary)) else $error("scale changed mid frame");
	chk_epoch_align: assert property (cycle_start && epoch |=> acc_r == '0) else $error("phase not reset at epoch");
	chk_wrap_residue: assert property (boundary && !epoch |-> acc_nxt < step_u) else $error("frame wrap residue too large");
	chk_capture_single: assert property (capture_r |=> !capture_r) else $error("capture pulse too long");
	chk_stamp_latch: assert property (due |=> stamp_r == $past(cycle_time)) else $error("capture time not latched");
	chk_stamp_first: assert property (pix_in.valid && pix_in.sof && stamp_en_r |=> pix_out.valid && pix_out.data == $past(stamp_r[31:24])) else $error("first pixel not timestamp");
	chk_pixel_pass: assert property (pix_in.valid && !stamp_en_r |=> pix_out.data == $past(pix_in.data)) else $error("pixel altered with stamp off");

endmodule : ftc_core

// [core/ftc_pkg.sv]
// Frame timing control: register map, field layout, reset values and carrier types
package ftc_pkg;

	// Register offsets
	localparam logic [15:0] ADDR_PERIOD = 16'h1240;
	localparam logic [15:0] ADDR_OFFSET = 16'h1244;
	localparam logic [15:0] ADDR_STAMP  = 16'h12f8;

	// Field positions (LSB-first numbering: field bit 0 is data bit 0)
	localparam int PRES_BIT      = 31;
	localparam int ON_BIT        = 25;
	localparam int VAL_W         = 12;
	localparam int STAMP_EN_BIT  = 0;
	localparam int RSV_HI_MSB    = 30;
	localparam int RSV_HI_LSB    = 26;
	localparam int RSV_LO_MSB    = 24;
	localparam int RSV_LO_LSB    = 12;

	// Bus cycle-time layout: seconds, cycle count, cycle offset
	localparam int CT_SEC_LSB    = 25;
	localparam int CT_CYC_LSB    = 12;

	// Scaling and timestamp figures
	localparam logic [9:0]       SCALE_NUM     = 10'h320;
	localparam logic [VAL_W-1:0] NOMINAL_SCALE = 12'h320;
	localparam logic [2:0]       STAMP_PIXELS  = 3'h4;
	localparam int               PIX_W         = 8;

	// Reset values
	localparam logic [VAL_W-1:0] PERIOD_RST    = 12'h320;
	localparam logic             PERIOD_ON_RST = 1'b1;
	localparam logic [VAL_W-1:0] OFFSET_RST    = 12'h000;
	localparam logic             OFFSET_ON_RST = 1'b1;
	localparam logic             STAMP_EN_RST  = 1'b0;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [15:0] addr;
		logic [31:0] wdata;
	} ftc_reg_req_t;

	typedef struct packed {
		logic        valid;
		logic [31:0] data;
	} ftc_reg_rsp_t;

	typedef struct packed {
		logic             valid;
		logic             sof;
		logic [PIX_W-1:0] data;
	} ftc_pix_t;

endpackage : ftc_pkg

// [verification/frame_timing_control_tb.sv]
// Self-checking bench for the frame timing control block
`timescale 1ns/100ps
module frame_timing_control_tb;
	logic                  clk = 1'b0;
	logic                  rst_b = 1'b0;
	logic                  run = 1'b0;
	logic                  cycle_start;
	logic [31:0]           cycle_time;
	logic [31:0]           lfsr_r = 32'ha04202a6;
	ftc_pkg::ftc_reg_req_t reg_req = '0;
	ftc_pkg::ftc_reg_rsp_t reg_rsp;
	ftc_pkg::ftc_pix_t     pix_in = '0;
	ftc_pkg::ftc_pix_t     pix_out;
	logic                  capture_pulse;
	logic [31:0]           capture_time;
	logic [31:0]           rq[$];
	logic [8:0]            pq[$];
	logic                  tx_busy = 1'b0;
	logic                  busy_q = 1'b0;
	logic [15:0]           nom_cycles = 16'h0004;
	int                    err_total = 0;
	int                    total_checks = 0;
	int                    cap_cnt = 0;
	always #2.5 clk = ~clk;
	ftc_bus_model i_ftc_bus_model (.clk(clk), .rst_b(rst_b), .run(run),
		.cycle_start(cycle_start), .cycle_time(cycle_time));
	ftc_core i_ftc_core (.clk(clk), .rst_b(rst_b), .reg_req(reg_req), .reg_rsp(reg_rsp),
		.cycle_start(cycle_start), .cycle_time(cycle_time), .nominal_cycles(nom_cycles),
		.tx_busy(tx_busy), .capture_pulse(capture_pulse), .capture_time(capture_time),
		.pix_in(pix_in), .pix_out(pix_out));
	function automatic logic [31:0] lfsr();
		lfsr_r = {lfsr_r[30:0], lfsr_r[31] ^ lfsr_r[21] ^ lfsr_r[1] ^ lfsr_r[0]};
		return lfsr_r;
	endfunction : lfsr
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask : chk
	task automatic report_and_stop();
		if (err_total == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : report_and_stop
	// One register access; a read notes its expected answer
	task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d);
		@(posedge clk) #1;
		reg_req = '{wr: w, rd: !w, addr: a, wdata: d};
		if (!w)
			rq.push_back(d);
		@(posedge clk) #1;
		reg_req = '0;
	endtask : bus
	// One image of six pixels; the first four carry the stamp when enabled
	task automatic frame(input logic en, input logic [31:0] st);
		logic [7:0] d;
		for (int i = 0; i < 6; i++) begin
			d = 8'(lfsr());
			@(posedge clk) #1;
			pix_in = '{valid: 1'b1, sof: (i == 0), data: d};
			pq.push_back({i == 0, (en && i < 4) ? st[31 - 8 * i -: 8] : d});
		end
		@(posedge clk) #1;
		pix_in = '0;
	endtask : frame
	// Thirty-two iso cycles; a frame in transmission covers the first capture of the first run
	task automatic run_frames();
		run = 1'b1;
		for (int c = 0; c < 128; c++) begin
			@(posedge clk) #1;
			tx_busy = (c >= 3 && c < 6);
		end
		run = 1'b0;
		repeat (8) @(posedge clk);
	endtask : run_frames
	always @(posedge clk) begin
		if (reg_rsp.valid)
			chk(reg_rsp.data, rq.pop_front());
		if (pix_out.valid)
			chk({23'h0, pix_out.sof, pix_out.data}, {23'h0, pq.pop_front()});
		if (capture_pulse) begin
			cap_cnt++;
			chk({31'h0, busy_q}, 32'h0);
		end
		busy_q = tx_busy;
	end
	initial begin
		#20000;
		err_total++;
		report_and_stop();
	end
	initial begin
		repeat (4) @(posedge clk);
		#1 rst_b = 1'b1;
		bus(1'b0, ftc_pkg::ADDR_PERIOD, 32'h82000320);
		bus(1'b0, ftc_pkg::ADDR_OFFSET, 32'h82000000);
		bus(1'b0, ftc_pkg::ADDR_STAMP, 32'h80000000);
		bus(1'b0, 16'h1248, 32'h0);
		run_frames();
		chk(cap_cnt, 32'h8);
		chk(capture_time, 32'h0001c000);
		frame(1'b0, 32'h0);
		bus(1'b1, ftc_pkg::ADDR_STAMP, lfsr() | 32'h1);
		bus(1'b0, ftc_pkg::ADDR_STAMP, 32'h80000001);
		frame(1'b1, 32'h0001c000);
		bus(1'b1, ftc_pkg::ADDR_PERIOD, (lfsr() & 32'hfdfff000) | 32'h3c0);
		bus(1'b0, ftc_pkg::ADDR_PERIOD, 32'h820003c0);
		bus(1'b1, ftc_pkg::ADDR_PERIOD, 32'h0);
		bus(1'b0, ftc_pkg::ADDR_PERIOD, 32'h80000000);
		bus(1'b1, ftc_pkg::ADDR_OFFSET, (lfsr() & 32'h7ffff000) | 32'h18);
		bus(1'b0, ftc_pkg::ADDR_OFFSET, 32'h82000018);
		// Offset of 24 units lands one iso cycle after each boundary: last capture moves from cycle 28 to 29
		run_frames();
		chk(cap_cnt, 32'h10);
		chk(capture_time, 32'h0003d000);
		repeat (4) @(posedge clk);
		chk(rq.size() + pq.size(), 32'h0);
		report_and_stop();
	end
endmodule : frame_timing_control_tb

// [verification/ftc_bus_model.sv]
// Bus timing source: cycle start pulses and a counting cycle time
`timescale 1ns/100ps
module ftc_bus_model (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst_b,
	// Control
	input  wire logic        run,
	// Bus timing
	output logic             cycle_start,
	output logic [31:0]      cycle_time
);
	logic [1:0] div_r;
	// First pulse carries the epoch value so all cameras share phase; updates land on the edge, so run is sampled cleanly
	always @(posedge clk) begin
		if (!rst_b) begin
			cycle_start <= 1'b0;
			cycle_time  <= 32'h0;
			div_r       <= 2'h0;
		end else begin
			if (cycle_start)
				cycle_time <= cycle_time + 32'h1000;
			cycle_start <= run && (div_r == 2'h3);
			div_r       <= run ? div_r + 2'h1 : 2'h0;
		end
	end
endmodule : ftc_bus_model
